/* common/bio_pkg.sv */
// shared constants and carriers for the byte i/o bus port
// assumes a single 20 MHz microcycle clock and the package compiled first
package bio_pkg;

    // ----------------------------------------
    // clock and command coding
    // ----------------------------------------
    localparam int CLK_MHZ = 20;
    localparam logic [3:0] OP_CTRL = 4'h7;
    localparam logic [3:0] OP_LOAD_T = 4'h1;
    localparam int C_IO_BIT = 3;
    localparam logic [3:0] C_CLEAR = 4'h8;

    // ----------------------------------------
    // bus modes held in bus_mode_control
    // ----------------------------------------
    typedef enum logic [2:0] {
        MODE_IDLE = 3'b000,
        MODE_CTRL_OUT = 3'b001,
        MODE_DATA_OUT = 3'b010,
        MODE_SERIAL_SPACE = 3'b011,
        MODE_CONC_ACK = 3'b100,
        MODE_IRQ_ACK = 3'b101,
        MODE_DATA_IN = 3'b110,
        MODE_SPARE = 3'b111
    } bio_mode_type;
    localparam int MODE_INPUT_FLAG_BIT = 2;
    localparam bio_mode_type MODE_RESET = MODE_IDLE;

    // ----------------------------------------
    // condition_and_line_flags layout
    // ----------------------------------------
    localparam int FLAG_OVF = 0;
    localparam int FLAG_NEG = 1;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_CONC_REQ = 3;
    localparam int FLAG_INT_IRQ = 4;
    localparam int FLAG_REPLY = 5;
    localparam int FLAG_SERIAL = 6;
    localparam int FLAG_EXT_IRQ = 7;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // ----------------------------------------
    // address byte and output transfer timing
    // ----------------------------------------
    localparam int FUNC_POS = 5;
    localparam int DEV_BITS = 5;
    localparam int STROBE_CLOCKS = 3;
    localparam logic [1:0] STROBE_LAST = 2'(STROBE_CLOCKS - 1);
    localparam logic [7:0] OD_RESET = 8'hFF;
    localparam logic [7:0] T_RESET = 8'h00;
    localparam logic [7:0] SRC_RESET = 8'h00;
    // low-active pins idle high, input bus and serial line idle low
    localparam logic [11:0] PIN_RESET = 12'h00E;

    typedef struct packed {
        logic [3:0] op;
        logic [3:0] c;
        logic [7:0] data;
    } bio_cmd_type;

    typedef struct packed {
        logic [2:0] func;
        logic [4:0] dev;
        logic [7:0] data;
    } bio_xfer_type;

    typedef struct packed {
        logic overflow;
        logic negative;
        logic zero;
        logic intIrq;
    } bio_cond_type;

endpackage

/* core/bio_out_buf.sv */
// two-entry valid/ready buffer for queued output transfers
// assumes same clock as its user; ready on the fill side is registered
`timescale 1ns/100ps
module bio_out_buf #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // pointers wrap by overflow, so only powers of two are served
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_params
        $error("bio_out_buf: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic inReady_q;

    wire push = inValid && inReady_q;
    wire pop = outValid && outReady;

    assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    assign outValid = (count_q != '0);
    assign outData = mem[rdPtr_q];
    assign inReady = inReady_q;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // ready is a flop so that the fill side sees a clean level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            inReady_q <= 1'b0;
        end else begin
            wrPtr_q <= wrPtr_q + AW'(push);
            rdPtr_q <= rdPtr_q + AW'(pop);
            count_q <= count_d;
            inReady_q <= (count_d < (AW+1)'(DEPTH));
        end
    end
endmodule

/* core/bio_port.sv */
// processor end of the byte i/o bus: mode register, flags, output sequencer
// assumes microprogram commands arrive on clk; bus pins are asynchronous
`timescale 1ns/100ps

module bio_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire bio_pkg::bio_cmd_type cmd,
    input wire bio_pkg::bio_cond_type cond,
    input wire logic xferValid,
    output logic xferReady,
    input wire bio_pkg::bio_xfer_type xfer,
    output logic [7:0] srcData,
    output logic srcValid,
    output logic [7:0] condFlags,
    output logic [7:0] outDataLines,
    output logic [2:0] modeLines,
    output logic xferDone,
    input wire logic [7:0] inBus,
    input wire logic extIrq_n,
    input wire logic ioReply_n,
    input wire logic concurrentReq_n,
    input wire logic serialIn
);
    import bio_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // low-active lines reset high so no false request shows at release
    logic [11:0] pinS1_q;
    logic [11:0] pinS2_q;
    wire [11:0] pinRaw = {inBus, extIrq_n, ioReply_n, concurrentReq_n, serialIn};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinS1_q <= PIN_RESET;
            pinS2_q <= PIN_RESET;
        end else begin
            pinS1_q <= pinRaw;
            pinS2_q <= pinS1_q;
        end
    end

    wire [7:0] inBusS = pinS2_q[11:4];
    wire irqS_n = pinS2_q[3];
    wire replyS_n = pinS2_q[2];
    wire creqS_n = pinS2_q[1];
    wire serialS = pinS2_q[0];

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_CODE = 2'b01,
        SEQ_GAP = 2'b10,
        SEQ_DATA = 2'b11
    } bio_seq_type;

    bio_seq_type seq_q;
    bio_seq_type seq_d;
    bio_mode_type mode_q;
    bio_mode_type mode_d;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic [7:0] tReg_q;
    logic [7:0] od_q;
    logic [7:0] od_d;
    logic [7:0] src_q;
    logic srcValid_q;
    logic [7:0] flags_q;
    logic cmdReady_q;
    logic done_q;
    bio_xfer_type xferQ_q;
    bio_xfer_type bufData;
    logic bufValid;

    function automatic logic [7:0] addr_byte(input bio_xfer_type x);
        addr_byte = {x.func, 1'b0, x.dev[DEV_BITS-2:0]};
    endfunction

    wire cmdFire = cmdValid && cmdReady_q;
    wire isCtrl = cmdFire && (cmd.op == OP_CTRL) && cmd.c[C_IO_BIT];
    wire isClear = isCtrl && (cmd.c == C_CLEAR);
    wire isSet = isCtrl && !isClear && (mode_q == MODE_IDLE);
    wire isLoadT = cmdFire && (cmd.op == OP_LOAD_T);
    wire inputFlag = mode_q[MODE_INPUT_FLAG_BIT];
    wire [7:0] srcSel = inputFlag ? inBusS : tReg_q;
    // sequencer only starts with the bus idle and no command competing
    wire seqStart = (seq_q == SEQ_IDLE) && bufValid && !cmdValid && (mode_q == MODE_IDLE);
    wire cntEnd = (cnt_q == 2'h0);

    // ----------------------------------------
    // mode register and output sequencer
    // ----------------------------------------
    always_comb begin
        seq_d = seq_q;
        mode_d = mode_q;
        cnt_d = cnt_q;
        od_d = od_q;
        case (seq_q)
            SEQ_IDLE: begin
                if (seqStart) begin
                    seq_d = SEQ_CODE;
                    mode_d = MODE_CTRL_OUT;
                    cnt_d = STROBE_LAST;
                    od_d = addr_byte(bufData);
                end else if (isClear) begin
                    mode_d = MODE_IDLE;
                end else if (isSet) begin
                    mode_d = bio_mode_type'(cmd.c[2:0]);
                end else if (isLoadT) begin
                    od_d = cmd.data;
                end
            end
            SEQ_CODE: begin
                cnt_d = cnt_q - 2'h1;
                if (cntEnd) begin
                    seq_d = SEQ_GAP;
                    mode_d = MODE_IDLE;
                    od_d = xferQ_q.data;
                end
            end
            SEQ_GAP: begin
                seq_d = SEQ_DATA;
                mode_d = MODE_DATA_OUT;
                cnt_d = STROBE_LAST;
            end
            SEQ_DATA: begin
                cnt_d = cnt_q - 2'h1;
                if (cntEnd) begin
                    seq_d = SEQ_IDLE;
                    mode_d = MODE_IDLE;
                end
            end
            default: begin
                seq_d = SEQ_IDLE;
                mode_d = MODE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_q <= SEQ_IDLE;
            mode_q <= MODE_RESET;
            cnt_q <= 2'h0;
            od_q <= OD_RESET;
            xferQ_q <= '0;
            cmdReady_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            seq_q <= seq_d;
            mode_q <= mode_d;
            cnt_q <= cnt_d;
            od_q <= od_d;
            if (seqStart) begin
                xferQ_q <= bufData;
            end
            cmdReady_q <= (seq_d == SEQ_IDLE);
            done_q <= (seq_q == SEQ_DATA) && cntEnd;
        end
    end

    // ----------------------------------------
    // T register, source data, flags
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tReg_q <= T_RESET;
            src_q <= SRC_RESET;
            srcValid_q <= 1'b0;
            flags_q <= FLAGS_RESET;
        end else begin
            if (isLoadT) begin
                tReg_q <= cmd.data;
            end
            srcValid_q <= isCtrl;
            if (isCtrl) begin
                src_q <= srcSel;
            end
            flags_q <= {!irqS_n, serialS, !replyS_n, cond.intIrq,
                        !creqS_n, cond.zero, cond.negative, cond.overflow};
        end
    end

    bio_out_buf #(.WIDTH($bits(bio_xfer_type)), .DEPTH(2)) u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(xferValid),
        .inReady(xferReady),
        .inData(xfer),
        .outValid(bufValid),
        .outReady(seqStart),
        .outData(bufData)
    );

    assign cmdReady = cmdReady_q;
    assign srcData = src_q;
    assign srcValid = srcValid_q;
    assign condFlags = flags_q;
    // data lines carry the false side of the output register
    assign outDataLines = ~od_q;
    assign modeLines = mode_q;
    assign xferDone = done_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_mode_hold;
        @(posedge clk) disable iff (!rst_n)
        (mode_q != MODE_IDLE) && !isClear && (seq_q == SEQ_IDLE) |=> $stable(mode_q);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed without clear");

    property p_set_mode;
        @(posedge clk) disable iff (!rst_n)
        isSet && !seqStart |=> modeLines == $past(cmd.c[2:0]);
    endproperty
    a_set_mode: assert property (p_set_mode) else $error("mode not loaded from c");

    property p_clear;
        @(posedge clk) disable iff (!rst_n)
        isClear && (seq_q == SEQ_IDLE) && !seqStart |=> modeLines == 3'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero mode");

    property p_ignore_low_c;
        @(posedge clk) disable iff (!rst_n)
        cmdFire && (cmd.op == OP_CTRL) && !cmd.c[C_IO_BIT] && !seqStart |=> $stable(mode_q);
    endproperty
    a_ignore_low_c: assert property (p_ignore_low_c) else $error("c below 8 changed mode");

    property p_code_strobe;
        @(posedge clk) disable iff (!rst_n)
        seqStart |=> (modeLines == 3'h1 && outDataLines == ~addr_byte(xferQ_q))[*3]
            ##1 modeLines == 3'h0 ##1 modeLines == 3'h2;
    endproperty
    a_code_strobe: assert property (p_code_strobe) else $error("output sequence wrong");

    property p_od_inverted;
        @(posedge clk) disable iff (!rst_n)
        $rose(seq_q == SEQ_DATA) |-> outDataLines == ~xferQ_q.data;
    endproperty
    a_od_inverted: assert property (p_od_inverted) else $error("data lines not inverted");

    property p_src_sel;
        @(posedge clk) disable iff (!rst_n)
        isCtrl |=> srcValid && srcData == ($past(inputFlag) ? $past(inBusS) : $past(tReg_q));
    endproperty
    a_src_sel: assert property (p_src_sel) else $error("source select wrong");

    property p_line_flags;
        @(posedge clk) disable iff (!rst_n)
        ##1 condFlags[FLAG_EXT_IRQ] == !$past(irqS_n) && condFlags[FLAG_REPLY] == !$past(replyS_n)
            && condFlags[FLAG_CONC_REQ] == !$past(creqS_n);
    endproperty
    a_line_flags: assert property (p_line_flags) else $error("line flag wrong");

    property p_cond_flags;
        @(posedge clk) disable iff (!rst_n)
        ##1 condFlags[FLAG_OVF] == $past(cond.overflow) && condFlags[FLAG_ZERO] == $past(cond.zero)
            && condFlags[FLAG_NEG] == $past(cond.negative)
            && condFlags[FLAG_INT_IRQ] == $past(cond.intIrq)
            && condFlags[FLAG_SERIAL] == $past(serialS);
    endproperty
    a_cond_flags: assert property (p_cond_flags) else $error("condition flag wrong");

    c_xfer_done: cover property (@(posedge clk) disable iff (!rst_n) xferDone);
    c_irq_ack: cover property (@(posedge clk) disable iff (!rst_n) modeLines == 3'h5);
    c_input_src: cover property (@(posedge clk) disable iff (!rst_n) isCtrl && inputFlag);
    c_buf_full: cover property (@(posedge clk) disable iff (!rst_n) !xferReady);
endmodule

/* verif/bio_periph_model.sv */
// peripheral interface board on the byte i/o bus, behavioural
// assumes mode and data lines straight from the port; master reset is rst_n
`timescale 1ns/100ps
module bio_periph_model
    import bio_pkg::*;
#(
    parameter logic [4:0] DEV = 5'h01,
    parameter logic [7:0] BOARD_IN = 8'h5A
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] modeLines,
    input wire logic [7:0] outDataLines,
    output logic [7:0] inBus,
    output logic ioReply_n,
    output logic [7:0][7:0] latches
);
    // ----------------------------------------
    // strobe decode
    // ----------------------------------------
    logic [7:0] odByte;
    logic ctrlOut, dataOut, dataIn, clkPulse, addrMatch, connQ;
    logic [2:0] funcQ, prevMode;
    assign odByte = ~outDataLines;
    assign ctrlOut = modeLines == MODE_CTRL_OUT;
    assign dataOut = modeLines == MODE_DATA_OUT;
    assign dataIn = modeLines == MODE_DATA_IN;
    assign clkPulse = ctrlOut | dataOut | dataIn;
    assign addrMatch = ctrlOut && odByte[4:0] == DEV;
    // terminated input lines rest at zero when nobody drives them
    assign inBus = (dataIn && connQ) ? BOARD_IN : 8'h00;
    // reply held while connected, a closed-loop board
    assign ioReply_n = ~connQ;

    // ----------------------------------------
    // connect, function and output latches
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            connQ <= 1'b0;
            funcQ <= 3'h0;
            prevMode <= 3'h0;
            latches <= '0;
        end else begin
            prevMode <= modeLines;
            if (addrMatch) begin
                connQ <= 1'b1;
            end else if ((prevMode == MODE_DATA_OUT || prevMode == MODE_DATA_IN)
                         && !dataOut && !dataIn) begin
                connQ <= 1'b0;
            end
            // data strobes would smear data into the function code
            if (clkPulse && ctrlOut) begin
                funcQ <= odByte[7:5];
            end
            if (dataOut && connQ) begin
                latches[funcQ] <= odByte;
            end
        end
    end
endmodule

/* verif/bio_port_bench.sv */
// self-checking bench: modes, flags, source select, output transfers
// assumes bio_pkg and the peripheral model are compiled before it
`timescale 1ns/100ps
module bio_port_bench;
    import bio_pkg::*;
    logic clk, rst_n, cmdValid, cmdReady, xferValid, xferReady, srcValid, xferDone;
    bio_cmd_type cmd;
    bio_cond_type cond;
    bio_xfer_type xfer, x;
    logic [7:0] srcData, condFlags, outDataLines, inBus, tReg, inVal, addr;
    logic [2:0] modeLines, curMode;
    logic extIrq_n, ioReply_n, concurrentReq_n, serialIn;
    logic [7:0][7:0] latches;
    int mismatches = 0;
    int n_checks = 0;
    int n;
    logic [7:0] srcQ[$];
    bio_xfer_type xQ[$];

    bio_port dut (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmd(cmd), .cond(cond), .xferValid(xferValid), .xferReady(xferReady), .xfer(xfer),
        .srcData(srcData), .srcValid(srcValid), .condFlags(condFlags),
        .outDataLines(outDataLines), .modeLines(modeLines), .xferDone(xferDone),
        .inBus(inBus), .extIrq_n(extIrq_n), .ioReply_n(ioReply_n),
        .concurrentReq_n(concurrentReq_n), .serialIn(serialIn));
    bio_periph_model #(.DEV(5'h01), .BOARD_IN(8'h5A)) model (.clk(clk), .rst_n(rst_n),
        .modeLines(modeLines), .outDataLines(outDataLines), .inBus(inBus),
        .ioReply_n(ioReply_n), .latches(latches));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // source byte predicted from the mode before the command
    task automatic send(logic [3:0] op, logic [3:0] c, logic [7:0] d);
        cmdValid <= 1'b1;
        cmd <= '{op: op, c: c, data: d};
        if (op == OP_CTRL && c[3]) srcQ.push_back(curMode[2] ? inVal : tReg);
        if (op == OP_LOAD_T) tReg = d;
        if (op == OP_CTRL && c == C_CLEAR) curMode = 3'h0;
        else if (op == OP_CTRL && c[3] && curMode == 3'h0) curMode = c[2:0];
        do @(posedge clk); while (cmdReady !== 1'b1);
        cmdValid <= 1'b0;
        @(posedge clk);
        check("mode", 8'(modeLines), 8'(curMode));
        check("odLines", outDataLines, ~tReg);
    endtask

    task automatic phase(logic [2:0] m, int cnt, logic [7:0] v);
        repeat (cnt) begin
            check("seqMode", 8'(modeLines), 8'(m));
            check("seqLines", outDataLines, ~v);
            @(posedge clk);
        end
    endtask

    // ----------------------------------------
    // result monitor
    // ----------------------------------------
    always @(posedge clk) begin
        if (srcValid === 1'b1) begin
            if (srcQ.size() == 0) begin
                mismatches++;
                $display("ERROR srcData expected none seen %h", srcData);
            end else check("srcData", srcData, srcQ.pop_front());
        end
        if (xferDone === 1'b1) begin
            if (xQ.size() == 0) begin
                mismatches++;
                $display("ERROR xferDone expected none seen 1");
            end else begin
                check("latch", latches[xQ[0].func], xQ[0].data);
                void'(xQ.pop_front());
            end
        end
    end

    initial begin
        #(4000 * 50);
        mismatches++;
        $display("ERROR watchdog expected finish seen hang");
        give_verdict();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        cmdValid = 1'b0;
        cmd = '0;
        cond = '0;
        xferValid = 1'b0;
        xfer = '0;
        extIrq_n = 1'b1;
        concurrentReq_n = 1'b1;
        serialIn = 1'b0;
        tReg = T_RESET;
        curMode = 3'h0;
        inVal = 8'h00;
        void'($urandom(32'hA0557853));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("rstMode", 8'(modeLines), 8'h00);
        check("rstLines", outDataLines, ~OD_RESET);
        @(posedge clk);
        send(OP_LOAD_T, 4'h0, 8'hA6);
        for (int m = 1; m < 8; m++) begin
            send(OP_CTRL, C_CLEAR | 4'(m), 8'h00);
            send(OP_CTRL, C_CLEAR | 4'(m % 7 + 1), 8'h00);
            send(OP_CTRL, 4'(m), 8'h00);
            send(OP_CTRL, C_CLEAR, 8'h00);
        end
        $display("test modes done");
        repeat (4) begin
            cond <= 4'($urandom);
            extIrq_n <= 1'($urandom);
            concurrentReq_n <= 1'($urandom);
            serialIn <= 1'($urandom);
            repeat (5) @(posedge clk);
            check("flags", condFlags, {~extIrq_n, serialIn, ~ioReply_n, cond.intIrq,
                ~concurrentReq_n, cond.zero, cond.negative, cond.overflow});
        end
        $display("test flags done");
        send(OP_LOAD_T, 4'h0, 8'h41);
        send(OP_CTRL, 4'h9, 8'h00);
        repeat (4) @(posedge clk);
        check("replyFlag", 8'(condFlags[FLAG_REPLY]), 8'h01);
        send(OP_CTRL, C_CLEAR, 8'h00);
        send(OP_CTRL, 4'hE, 8'h00);
        inVal = 8'h5A;
        repeat (4) @(posedge clk);
        send(OP_CTRL, C_CLEAR, 8'h00);
        inVal = 8'h00;
        $display("test input done");
        x = '{func: 3'h0, dev: 5'h01, data: 8'($urandom)};
        addr = {x.func, 1'b0, x.dev[3:0]};
        xQ.push_back(x);
        xfer <= x;
        xferValid <= 1'b1;
        @(posedge clk);
        xferValid <= 1'b0;
        n = 0;
        while (modeLines !== MODE_CTRL_OUT && n < 12) begin
            @(posedge clk);
            n++;
        end
        phase(3'h1, 3, addr);
        phase(3'h0, 1, x.data);
        phase(3'h2, 3, x.data);
        phase(3'h0, 1, x.data);
        $display("test transfer done");
        cmdValid <= 1'b1;
        cmd <= '0;
        for (int i = 1; i < 5; i++) begin
            x = '{func: 3'(i), dev: 5'h01, data: 8'($urandom)};
            xQ.push_back(x);
            xfer <= x;
            xferValid <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (xferReady !== 1'b1 && n < 200);
            if (i == 2) cmdValid <= 1'b0;
        end
        xferValid <= 1'b0;
        n = 0;
        while (xQ.size() != 0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        check("drained", 8'(xQ.size()), 8'h00);
        $display("test burst done");
        repeat (3) @(posedge clk);
        give_verdict();
    end
endmodule
